// ### verilog/ssd_pkg.sv
// What this block does
// - Shutdown while running drops all gate drive
// - Fault relay released while shutdown cause persists
// - Shutdown code sent; panel shows its message
// - Wishbone register supplies full-load current for overload base
// - Highest phase current against 1.05 full-load
// - Overload held 40 seconds raises shutdown
// - Any heatsink above 212F raises shutdown
// - Pump stays on until all below 109F
// - Heat shutdown code names phase A, B, C
// - Pump output on while the starter is running
// - Stop contact closed only while no fault
// - Six gate outputs only while running
// - Pump on above 110F, off below it
package ssd_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int OVL_TIME_S = 40;
  localparam logic [5:0] OVL_SECS = 6'(OVL_TIME_S);

  // ----------------------------------------
  // Thresholds
  // ----------------------------------------
  localparam logic [23:0] OVL_NUM = 24'h000069;
  localparam logic [23:0] OVL_DEN = 24'h000064;
  localparam logic [15:0] TEMP_TRIP_F = 16'h00D4;
  localparam logic [15:0] TEMP_PUMP_F = 16'h006E;
  localparam logic [15:0] TEMP_HOLD_F = 16'h006D;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_FLC = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_OVL_CNT = 8'h10;
  localparam logic [15:0] FLC_RESET = 16'h0000;
  localparam int IRQ_W = 2;
  localparam int IRQ_OVL = 0;
  localparam int IRQ_HOT = 1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } ssd_tri_t;

  typedef enum logic [2:0] {
    CODE_NONE = 3'h0,
    CODE_OVL = 3'h1,
    CODE_HOT_A = 3'h2,
    CODE_HOT_B = 3'h3,
    CODE_HOT_C = 3'h4
  } ssd_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TRIP = 2'b10
  } ssd_state_t;

endpackage

// ### verilog/ssd_tick.sv
`timescale 1ns/1ps
module ssd_tick #(
  parameter int DIV = 200_000_000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // One-cycle enable
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;

  generate
    if (DIV < 2) begin : g_bad
      $error("ssd_tick: DIV must be at least 2");
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == CW'(DIV - 1));
      cnt_q <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

// ### verilog/ssd_top.sv
`timescale 1ns/1ps
module ssd_top #(
  parameter int SEC_CYCLES = ssd_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Panel side
  input wire logic run_cmd,
  output logic fault_relay,
  output logic code_stb,
  output ssd_pkg::ssd_code_t code,
  // Measurements
  input wire ssd_pkg::ssd_tri_t rms_current,
  input wire ssd_pkg::ssd_tri_t heatsink_temp,
  // Power stage
  output logic [5:0] gate,
  output logic pump_relay
);
  import ssd_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (SEC_CYCLES < 2) begin : g_bad_sec
      $error("ssd_top: SEC_CYCLES must be at least 2");
    end
    // Six-bit second counter saturates at the overload time
    if (OVL_TIME_S < 1 || OVL_TIME_S > 63) begin : g_bad_ovl
      $error("ssd_top: overload time must fit the counter");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ssd_state_t state_q, state_d;
  logic [15:0] flc_q;
  logic [5:0] ovl_cnt_q, ovl_cnt_d;
  logic [IRQ_W-1:0] ista_q, imask_q;
  logic hold_q, warm_q, sec_tick;

  ssd_tick #(
    .DIV(SEC_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(sec_tick)
  );

  // ----------------------------------------
  // Overload supervision
  // ----------------------------------------
  wire [15:0] max_ab_w = (rms_current.a > rms_current.b) ?
                         rms_current.a : rms_current.b;
  wire [15:0] max_w = (max_ab_w > rms_current.c) ?
                      max_ab_w : rms_current.c;
  // Cross-multiplied so 1.05 needs no fraction
  wire over_w = (24'(max_w) * OVL_DEN) > (24'(flc_q) * OVL_NUM);
  wire ovl_done_w = over_w && sec_tick && (ovl_cnt_q == OVL_SECS - 6'h01);
  wire ovl_trip_w = (state_q == ST_RUN) && ovl_done_w;

  always_comb begin
    ovl_cnt_d = ovl_cnt_q;
    if (!over_w || state_q != ST_RUN) begin
      ovl_cnt_d = 6'h00;
    end else if (sec_tick && ovl_cnt_q != OVL_SECS) begin
      ovl_cnt_d = ovl_cnt_q + 6'h01;
    end
  end

  // ----------------------------------------
  // Heatsink supervision
  // ----------------------------------------
  wire hot_a_w = heatsink_temp.a > TEMP_TRIP_F;
  wire hot_b_w = heatsink_temp.b > TEMP_TRIP_F;
  wire hot_c_w = heatsink_temp.c > TEMP_TRIP_F;
  wire hot_w = hot_a_w || hot_b_w || hot_c_w;
  wire warm_on_w = (heatsink_temp.a > TEMP_PUMP_F) ||
                   (heatsink_temp.b > TEMP_PUMP_F) ||
                   (heatsink_temp.c > TEMP_PUMP_F);
  wire cool_w = (heatsink_temp.a < TEMP_PUMP_F) &&
                (heatsink_temp.b < TEMP_PUMP_F) &&
                (heatsink_temp.c < TEMP_PUMP_F);
  wire cold_w = (heatsink_temp.a < TEMP_HOLD_F) &&
                (heatsink_temp.b < TEMP_HOLD_F) &&
                (heatsink_temp.c < TEMP_HOLD_F);
  // Phase A wins when several trip together
  wire ssd_code_t hot_code_w = hot_a_w ? CODE_HOT_A :
                               hot_b_w ? CODE_HOT_B : CODE_HOT_C;
  wire hot_trip_w = hot_w && state_q != ST_TRIP;
  wire trip_w = ovl_trip_w || hot_trip_w;
  wire ssd_code_t trip_code_w = ovl_trip_w ? CODE_OVL : hot_code_w;
  wire cause_w = hot_w || over_w;

  // ----------------------------------------
  // Starter state
  // ----------------------------------------
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = hot_w ? ST_TRIP :
                         run_cmd ? ST_RUN : ST_IDLE;
      ST_RUN: state_d = trip_w ? ST_TRIP :
                        run_cmd ? ST_RUN : ST_IDLE;
      // Cleared only by cause gone and run removed
      ST_TRIP: state_d = (!cause_w && !run_cmd) ?
                         ST_IDLE : ST_TRIP;
      default: state_d = ST_IDLE;
    endcase
  end

  wire run_d_w = (state_d == ST_RUN);
  wire fault_d_w = (state_d == ST_TRIP);
  wire hold_d_w = (hot_w && hot_trip_w) || (hold_q && !cold_w);
  wire warm_d_w = warm_on_w || (warm_q && !cool_w);
  wire pump_d_w = (state_q == ST_RUN) || hold_q || warm_d_w;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ovl_cnt_q <= 6'h00;
      hold_q <= 1'b0;
      warm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ovl_cnt_q <= ovl_cnt_d;
      hold_q <= hold_d_w;
      warm_q <= warm_d_w;
    end
  end

  // ----------------------------------------
  // Outputs to power stage and panel
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate <= 6'h00;
      fault_relay <= 1'b0;
      pump_relay <= 1'b0;
      code_stb <= 1'b0;
      code <= CODE_NONE;
    end else begin
      gate <= {6{run_d_w}};
      fault_relay <= !fault_d_w;
      pump_relay <= pump_d_w;
      code_stb <= trip_w;
      if (trip_w) begin
        code <= trip_code_w;
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w = req_w && wb_we_i;
  wire sel_flc_w = (wb_adr_i == REG_FLC);
  wire sel_ist_w = (wb_adr_i == REG_IRQ_STAT);
  wire sel_msk_w = (wb_adr_i == REG_IRQ_MASK);
  wire [IRQ_W-1:0] ev_w = {hot_trip_w, ovl_trip_w};
  wire [IRQ_W-1:0] w1c_w = (wr_w && sel_ist_w && wb_sel_i[0]) ?
                           wb_dat_i[IRQ_W-1:0] : '0;
  // Set beats clear in the same cycle
  wire [IRQ_W-1:0] ista_d_w = (ista_q & ~w1c_w) | ev_w;
  wire [31:0] status_w = {25'h0000000, hold_q, warm_q, code,
                          state_q};
  wire [31:0] rd_w =
    (wb_adr_i == REG_FLC) ? {16'h0000, flc_q} :
    (wb_adr_i == REG_STATUS) ? status_w :
    (wb_adr_i == REG_IRQ_STAT) ? {30'h00000000, ista_q} :
    (wb_adr_i == REG_IRQ_MASK) ? {30'h00000000, imask_q} :
    (wb_adr_i == REG_OVL_CNT) ? {26'h0000000, ovl_cnt_q} :
    32'h00000000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      flc_q <= FLC_RESET;
      imask_q <= '0;
      ista_q <= '0;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= req_w ? rd_w : 32'h00000000;
      if (wr_w && sel_flc_w && wb_sel_i[0]) begin
        flc_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_w && sel_flc_w && wb_sel_i[1]) begin
        flc_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr_w && sel_msk_w && wb_sel_i[0]) begin
        imask_q <= wb_dat_i[IRQ_W-1:0];
      end
      ista_q <= ista_d_w;
      irq <= |(ista_d_w & imask_q);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gates_off_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_TRIP) |-> (gate == 6'h00))
    else $error("gates driven during shutdown");

  relay_open_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_TRIP) |-> !fault_relay)
    else $error("fault relay closed during shutdown");

  relay_closed_a: assert property (@(posedge mclk) disable iff (rst)
    (state_d != ST_TRIP) |=> fault_relay)
    else $error("fault relay open with no fault");

  code_sent_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_q == ST_TRIP) |-> code_stb && (code != CODE_NONE))
    else $error("no shutdown code on trip");

  ovl_trip_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_RUN && ovl_done_w) |=> (state_q == ST_TRIP)
      && (code == CODE_OVL))
    else $error("overload did not trip after full interval");

  ovl_clear_a: assert property (@(posedge mclk) disable iff (rst)
    !over_w |=> (ovl_cnt_q == 6'h00))
    else $error("overload timer not cleared");

  hot_trip_a: assert property (@(posedge mclk) disable iff (rst)
    (hot_w && state_q != ST_TRIP) |=> (state_q == ST_TRIP))
    else $error("heatsink over trip level did not shut down");

  hot_phase_a: assert property (@(posedge mclk) disable iff (rst)
    (hot_trip_w && !ovl_trip_w && hot_b_w && !hot_a_w)
      |=> (code == CODE_HOT_B))
    else $error("wrong phase in heat shutdown code");

  pump_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (hold_q && !cold_w) |=> pump_relay [*2])
    else $error("pump stopped before heatsinks cooled");

  pump_run_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_RUN) |=> pump_relay)
    else $error("pump off while running");

  pump_warm_a: assert property (@(posedge mclk) disable iff (rst)
    warm_on_w |=> pump_relay)
    else $error("pump off above pump temperature");

  gate_run_a: assert property (@(posedge mclk) disable iff (rst)
    (gate != 6'h00) |-> (state_q == ST_RUN) && (gate == 6'h3F))
    else $error("gates driven while not running");

  latch_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_TRIP && (run_cmd || cause_w)) |=> (state_q == ST_TRIP))
    else $error("shutdown released too early");

  code_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    code_stb |=> !code_stb)
    else $error("shutdown code strobe longer than one cycle");

  max_phase_a: assert property (@(posedge mclk) disable iff (rst)
    over_w == ((24'(rms_current.a) * OVL_DEN > 24'(flc_q) * OVL_NUM) ||
      (24'(rms_current.b) * OVL_DEN > 24'(flc_q) * OVL_NUM) ||
      (24'(rms_current.c) * OVL_DEN > 24'(flc_q) * OVL_NUM)))
    else $error("overload compare not on highest phase");

  ovl_idle_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q != ST_RUN) |=> (ovl_cnt_q == 6'h00))
    else $error("overload timer counting while not running");

  run_start_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_IDLE && run_cmd && !hot_w)
      |=> (state_q == ST_RUN) && (gate == 6'h3F))
    else $error("run command did not start the starter");

  hold_set_a: assert property (@(posedge mclk) disable iff (rst)
    hot_trip_w |=> hold_q ##1 pump_relay)
    else $error("pump hold not taken on heat shutdown");

  pump_stop_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q != ST_RUN && !hold_q && cool_w) |=> !pump_relay)
    else $error("pump running while commanded to stop");

  ovl_flag_a: assert property (@(posedge mclk) disable iff (rst)
    ev_w[IRQ_OVL] |=> ista_q[IRQ_OVL])
    else $error("overload event lost in status");

  hot_flag_a: assert property (@(posedge mclk) disable iff (rst)
    ev_w[IRQ_HOT] |=> ista_q[IRQ_HOT])
    else $error("heat event lost in status");

  // Mask written last cycle leaves irq one cycle behind
  irq_level_a: assert property (@(posedge mclk) disable iff (rst)
    $stable(imask_q) |-> (irq == |(ista_q & imask_q)))
    else $error("interrupt level disagrees with status and mask");

  ack_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");

endmodule

// ### verif/ssd_panel.sv
`timescale 1ns/1ps
module ssd_panel #(
  parameter int COAST = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operator request
  input wire logic want_run,
  // Starter side
  input wire logic fault_relay,
  input wire logic code_stb,
  input wire ssd_pkg::ssd_code_t code,
  output logic run_cmd,
  output ssd_pkg::ssd_code_t shown
);
  import ssd_pkg::*;
  // ----------------------------------------
  // Coastdown and restart
  // ----------------------------------------
  // Coastdown shortened to cycles to keep the run brief
  int coast_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_cmd <= 1'b0;
      coast_q <= 0;
      shown <= CODE_NONE;
    end else if (code_stb) begin
      shown <= code;
      run_cmd <= 1'b0;
      coast_q <= COAST;
    end else if (coast_q != 0) begin
      coast_q <= coast_q - 1;
    end else begin
      run_cmd <= want_run && fault_relay;
    end
  end
endmodule

// ### verif/test_starter_safety_shutdown.sv
`timescale 1ns/1ps
module test_starter_safety_shutdown;
  import ssd_pkg::*;
  localparam int SEC = 10;
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic want = 1'b0;
  logic [3:0] sel = 4'h3, lanes = 4'h3;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, seed = 32'h4D;
  logic ack, irq, run, relay, cstb, pump;
  logic [5:0] gate;
  ssd_code_t code, shown;
  ssd_tri_t cur = '0, tmp = '0;
  int mismatches = 0, checks = 0, tcnt = 0, i, p, n;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  ssd_top #(.SEC_CYCLES(SEC)) DUT (.mclk(mclk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq(irq), .run_cmd(run), .fault_relay(relay), .code_stb(cstb),
    .code(code), .rms_current(cur), .heatsink_temp(tmp), .gate(gate),
    .pump_relay(pump));
  ssd_panel #(.COAST(50)) panel (.mclk(mclk), .rst(rst),
    .want_run(want), .fault_relay(relay), .code_stb(cstb), .code(code),
    .run_cmd(run), .shown(shown));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function ssd_tri_t rtri(int b, int m);
    rtri.a = 16'(b + rnd() % m);
    rtri.b = 16'(b + rnd() % m);
    rtri.c = 16'(b + rnd() % m);
  endfunction
  function ssd_tri_t hot(int ph);
    hot = '{16'h32, 16'h32, 16'h32};
    if (ph == 0) hot.a = 16'hD5;
    if (ph == 1) hot.b = 16'hD5;
    if (ph == 2) hot.c = 16'hD5;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wait_code();
    n = 0;
    while (cstb !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ceiling well above the under a thousand cycles the run needs
  always @(posedge mclk) begin
    tcnt <= tcnt + 1;
    if (tcnt == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    step(10);
    rst <= 1'b0;
    step(2);
    chk("relay idle", 1, relay);
    wb(0, REG_FLC, 0);
    chk("flc reset", FLC_RESET, q);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, q);
    lanes = 4'h1;
    wb(1, REG_FLC, 32'h0000AB64);
    lanes = 4'h3;
    wb(0, REG_FLC, 0);
    chk("flc lane", 32'h64, q);
    wb(1, REG_FLC, 32'h64);
    want <= 1'b1;
    step(4);
    chk("gate run", 6'h3F, gate);
    chk("pump run", 1, pump);
    for (i = 0; i < 40; i++) begin
      cur <= rtri(0, 106);
      tmp <= rtri(50, 60);
      step(1);
      chk("no trip", 6'h3F, gate);
    end
    cur <= '{16'h69, 16'h6A, 16'h10};
    step(150);
    wb(0, REG_OVL_CNT, 0);
    chk("ovl counting", 1, q >= 14 && q <= 16);
    cur <= '{16'h69, 16'h69, 16'h69};
    step(3);
    wb(0, REG_OVL_CNT, 0);
    chk("ovl cleared", 0, q);
    cur <= '{16'h10, 16'h10, 16'h6A};
    step(1);
    wait_code();
    chk("ovl time", 1, n >= 388 && n <= 402);
    chk("ovl code", CODE_OVL, code);
    chk("gate off", 0, gate);
    chk("relay open", 0, relay);
    step(2);
    chk("shown", CODE_OVL, shown);
    wb(0, REG_STATUS, 0);
    chk("status", 32'h6, q);
    chk("irq masked", 0, irq);
    wb(0, REG_IRQ_STAT, 0);
    chk("irq stat", 1, q);
    wb(1, REG_IRQ_MASK, 3);
    step(2);
    chk("irq on", 1, irq);
    wb(1, REG_IRQ_STAT, 1);
    step(2);
    chk("irq clr", 0, irq);
    step(20);
    chk("relay held", 0, relay);
    cur <= rtri(0, 50);
    step(3);
    chk("relay back", 1, relay);
    i = 0;
    while (gate !== 6'h3F && i < 200) begin
      step(1);
      i++;
    end
    chk("restart", 6'h3F, gate);
    want <= 1'b0;
    step(4);
    chk("gate stop", 0, gate);
    tmp <= '{16'h6F, 16'h32, 16'h32};
    step(3);
    chk("pump warm", 1, pump);
    tmp.a <= 16'h6E;
    step(3);
    chk("pump at 110", 1, pump);
    tmp.a <= 16'h6D;
    step(3);
    chk("pump cool", 0, pump);
    tmp <= '{16'h6D, 16'hD4, 16'h6D};
    step(3);
    chk("212 no trip", 1, relay);
    for (p = 0; p < 3; p++) begin
      tmp <= hot(p);
      step(1);
      wait_code();
      chk("heat code", 32'(2 + p), code);
      step(1);
      chk("heat relay", 0, relay);
      tmp <= '{16'h6D, 16'h6D, 16'h6D};
      step(3);
      chk("pump hold", 1, pump);
      tmp <= '{16'h6C, 16'h6C, 16'h6C};
      step(3);
      chk("pump off", 0, pump);
      chk("heat clear", 1, relay);
    end
    test_done();
  end
endmodule
